// >>> core/icu_pkg.sv
// constants shared by the maskable and non-maskable interrupt unit
package icu_pkg;

   // ----------------------------------------
   // core bus and register offsets
   // ----------------------------------------
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam logic [15:0] VECTOR_OFS = 16'hFE00;
   localparam logic [15:0] NMI_STATUS_OFS = 16'hFE02;
   localparam logic [15:0] PEND_LOW_OFS = 16'hFE0A;
   localparam logic [15:0] PEND_HIGH_OFS = 16'hFE0C;
   localparam logic [15:0] ENA_LOW_OFS = 16'hFE0E;
   localparam logic [15:0] ENA_HIGH_OFS = 16'hFE10;
   localparam logic [15:0] CLR_LOW_OFS = 16'hFE12;
   localparam logic [15:0] CLR_HIGH_OFS = 16'hFE14;

   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int unsigned NUM_CH = 32;
   localparam int unsigned VEC_W = 6;
   localparam logic [5:0] VEC_BASE = 6'h10;
   localparam logic [7:0] VECTOR_RST = 8'h10;
   localparam logic [7:0] NMI_STATUS_RST = 8'h00;
   localparam int unsigned NMI_PIN_BIT = 0;
   localparam logic [31:0] ENA_RST = 32'h0000_0000;

   // ----------------------------------------
   // channel assignment
   // ----------------------------------------
   localparam int unsigned CH_KBD_SCAN = 11;
   localparam int unsigned CH_TICK = 13;
   localparam int unsigned CH_SERIAL = 16;
   localparam int unsigned CH_SHIFT3 = 18;
   localparam int unsigned CH_SHIFT2 = 19;
   localparam int unsigned CH_SHIFT1 = 20;
   localparam int unsigned CH_KBD_IBF = 24;
   localparam int unsigned CH_PIN_TOP = 31;
   // external pin channels 1, 6, 14, 17, 21, 31
   localparam logic [31:0] PIN_CH_MASK = 32'h8022_4042;
   // channel 0 and reserved channels 15, 26, 29, 30
   localparam logic [31:0] DEAD_CH_MASK = 32'h6400_8001;

endpackage

// >>> core/pend_cell.sv
// one pending cell: level follower or edge latch with write-one clear
`timescale 1ns/1ps
`default_nettype none
module pend_cell
   import icu_pkg::*;
#(
   parameter bit FALLING = 1'b0 // edge polarity when edge mode
)
(
   input wire logic clk, // core clock
   input wire logic rst_b, // sync reset, active low
   input wire logic src, // request from source
   input wire logic edge_mode, // 1: edge latched, 0: level
   input wire logic clr, // write-one clear strobe
   output logic pend // pending indication
);

   logic prev_r;
   logic prev_nxt;
   logic pend_r;
   logic pend_nxt;
   logic hit;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // set beats clear so a tick landing on the clear write is kept
   always_comb
   begin
      prev_nxt = src;
      hit = FALLING ? (prev_r & ~src) : (~prev_r & src);
      if (!edge_mode)
      begin
         pend_nxt = src;
      end
      else if (hit)
      begin
         pend_nxt = 1'b1;
      end
      else if (clr)
      begin
         pend_nxt = 1'b0;
      end
      else
      begin
         pend_nxt = pend_r;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         prev_r <= FALLING;
         pend_r <= 1'b0;
      end
      else
      begin
         prev_r <= prev_nxt;
         pend_r <= pend_nxt;
      end
   end

   assign pend = pend_r;

endmodule
`default_nettype wire

// >>> core/maskable_nmi_interrupt_unit.sv
// interrupt control unit: 32 maskable channels, vector register, nmi status
//
// Summary of operation
// R1: fixed priority; channel 31, external level request, is highest.
// R2: channel 13 latches rising edges of the system tick.
// R3: channels 18 and 19 latch falling edges of their shift lines.
// R4: channel 20 is level high, falling edge while disabled-shift enable is 1.
// R5: external channel whose pin is a plain port is forced to 0.
// R6: software should disable the tick channel in the wake-up unit when active.
// R7: channel 11 is level: keyboard scan OR auxiliary monitor request.
// R8: channel 16 is level: serial transmit OR receive request.
// R9: channel 24 is level while keyboard input buffer is full.
// R10: vector register resets to 10 hex and holds the serviced vector.
// R11: vector encodes highest enabled pending request, range 10 to 2F hex.
// R12: vector stays stable during the acknowledge read.
// R13: vector bits 7 and 6 always read 0.
// R14: nmi status clears on reset and on every read, except a read in the same cycle as a new set.
// R15: nmi bit 0 set by external request; bits 7 to 1 reserved.
// R16: both enable-mask registers are read and write.
// R17: both edge clear registers are write only, read as zero.
// R18: channels 15, 26, 29, 30 are tied inactive.
// R19: vector 10 hex is channel 0, 2F hex is channel 31.
// R20: edge requests latch; writing 1 to the clear bit drops them.
// R21: level pending follows its source directly.
// R22: nmi request to the core while the external nmi bit is 1.
`timescale 1ns/1ps
`default_nettype none
module maskable_nmi_interrupt_unit
   import icu_pkg::*;
(
   input wire logic clk, // core clock, 200 MHz
   input wire logic rst_b, // sync reset, active low
   // core bus
   input wire logic [ADDR_W-1:0] bus_addr, // byte address
   input wire logic bus_rd, // read strobe, one cycle
   input wire logic bus_wr, // write strobe, one cycle
   input wire logic [DATA_W-1:0] bus_wdata, // write data
   output logic [DATA_W-1:0] bus_rdata, // read data, next cycle
   output logic bus_rvalid, // read data valid pulse
   // sources
   input wire logic [NUM_CH-1:0] level_irq, // plain level channels
   input wire logic [NUM_CH-1:0] pin_irq, // external pins via wake-up unit
   input wire logic [NUM_CH-1:0] pin_alt_fn, // 1: pin in alternate function
   input wire logic system_tick_output, // tick via wake-up unit
   input wire logic shift_irq_line_one, // shift line to channel 20
   input wire logic shift_irq_line_two, // shift line to channel 19
   input wire logic shift_irq_line_three, // shift line to channel 18
   input wire logic disabled_shift_irq_enable, // serial port enable bit
   input wire logic keyboard_scan_irq, // keyboard scan via wake-up unit
   input wire logic auxiliary_monitor_irq, // auxiliary monitor request
   input wire logic serial_tx_irq, // serial transmit request
   input wire logic serial_rx_irq, // serial receive request
   input wire logic kbd_ibf, // host keyboard input buffer full
   input wire logic power_fail_input, // external nmi pin, falling edge
   input wire logic nmi_arm, // power-fail nmi enabled
   // core requests
   output logic irq_req, // maskable request to core
   output logic nmi_req // non-maskable request to core
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [NUM_CH-1:0] src;
   logic [NUM_CH-1:0] edge_sel;
   logic [NUM_CH-1:0] clr_bits;
   logic [NUM_CH-1:0] pend;
   logic [NUM_CH-1:0] ena_r;
   logic [NUM_CH-1:0] ena_nxt;
   logic [7:0] vec_r;
   logic [7:0] vec_nxt;
   logic [7:0] nmi_r;
   logic [7:0] nmi_nxt;
   logic pf_prev_r;
   logic pf_prev_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [NUM_CH-1:0] live;
   logic [VEC_W-1:0] win;
   logic ack_rd;
   logic nmi_rd;
   logic nmi_set;

   // ----------------------------------------
   // source routing
   // ----------------------------------------
   // external pins not in alternate function read as 0 here
   always_comb
   begin
      src = level_irq & ~PIN_CH_MASK;
      src = src | (pin_irq & pin_alt_fn & PIN_CH_MASK); // R5 R1
      src[CH_KBD_SCAN] = keyboard_scan_irq | auxiliary_monitor_irq; // R7
      src[CH_TICK] = system_tick_output; // R2
      src[CH_SERIAL] = serial_tx_irq | serial_rx_irq; // R8
      src[CH_SHIFT3] = shift_irq_line_three; // R3
      src[CH_SHIFT2] = shift_irq_line_two; // R3
      src[CH_SHIFT1] = shift_irq_line_one; // R4
      src[CH_KBD_IBF] = kbd_ibf; // R9
      src = src & ~DEAD_CH_MASK; // R18
   end

   // edge or level per channel
   always_comb
   begin
      edge_sel = '0;
      edge_sel[CH_TICK] = 1'b1; // R2
      edge_sel[CH_SHIFT3] = 1'b1; // R3
      edge_sel[CH_SHIFT2] = 1'b1; // R3
      edge_sel[CH_SHIFT1] = disabled_shift_irq_enable; // R4
   end

   // write-one clear strobes, edge channels only take effect
   always_comb
   begin
      clr_bits = '0;
      if (bus_wr && bus_addr == CLR_LOW_OFS)
      begin
         clr_bits[15:0] = bus_wdata; // R20
      end
      if (bus_wr && bus_addr == CLR_HIGH_OFS)
      begin
         clr_bits[31:16] = bus_wdata; // R20
      end
   end

   // ----------------------------------------
   // pending cells
   // ----------------------------------------
   // channel 13 rises, the shift lines fall
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_cell
         pend_cell #(
            .FALLING(g != CH_TICK)
         ) u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .src(src[g]),
            .edge_mode(edge_sel[g]),
            .clr(clr_bits[g]),
            .pend(pend[g])
         ); // R20 R21
      end
   endgenerate

   // ----------------------------------------
   // priority encoder
   // ----------------------------------------
   // highest index wins; nothing live falls back to channel 0
   always_comb
   begin
      live = pend & ena_r & ~DEAD_CH_MASK; // R11 R18
      win = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (live[i])
         begin
            win = VEC_W'(i); // R1 R19
         end
      end
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign ack_rd = bus_rd && (bus_addr == VECTOR_OFS);
   assign nmi_rd = bus_rd && (bus_addr == NMI_STATUS_OFS);

   // enable masks, full read and write
   always_comb
   begin
      ena_nxt = ena_r;
      if (bus_wr && bus_addr == ENA_LOW_OFS)
      begin
         ena_nxt[15:0] = bus_wdata; // R16
      end
      if (bus_wr && bus_addr == ENA_HIGH_OFS)
      begin
         ena_nxt[31:16] = bus_wdata; // R16
      end
   end

   // vector frozen during the acknowledge read so the core sees one value
   always_comb
   begin
      vec_nxt = vec_r;
      if (!ack_rd)
      begin
         vec_nxt = {2'b00, VEC_BASE + win}; // R11 R13 R19
      end
   end
   // R12 covered by the hold above

   // ----------------------------------------
   // non-maskable status
   // ----------------------------------------
   // falling edge of the power-fail pin while armed; set beats read clear
   always_comb
   begin
      pf_prev_nxt = power_fail_input;
      nmi_set = nmi_arm & pf_prev_r & ~power_fail_input;
      nmi_nxt = nmi_r;
      if (nmi_rd)
      begin
         nmi_nxt = NMI_STATUS_RST; // R14
      end
      if (nmi_set)
      begin
         nmi_nxt[NMI_PIN_BIT] = 1'b1; // R15
      end
      nmi_nxt[7:1] = 7'h00; // R15
   end

   // ----------------------------------------
   // read data and requests
   // ----------------------------------------
   // read data registered; clear registers and unmapped read as zero
   always_comb
   begin
      rvalid_nxt = bus_rd;
      rdata_nxt = 16'h0000;
      if (bus_rd)
      begin
         case (bus_addr)
            VECTOR_OFS: rdata_nxt = {8'h00, vec_r}; // R12 R13
            NMI_STATUS_OFS: rdata_nxt = {8'h00, nmi_r}; // R14
            PEND_LOW_OFS: rdata_nxt = pend[15:0];
            PEND_HIGH_OFS: rdata_nxt = pend[31:16];
            ENA_LOW_OFS: rdata_nxt = ena_r[15:0]; // R16
            ENA_HIGH_OFS: rdata_nxt = ena_r[31:16]; // R16
            CLR_LOW_OFS: rdata_nxt = 16'h0000; // R17
            CLR_HIGH_OFS: rdata_nxt = 16'h0000; // R17
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   assign irq_nxt = |live;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ena_r <= ENA_RST;
         vec_r <= VECTOR_RST; // R10
         nmi_r <= NMI_STATUS_RST; // R14
         pf_prev_r <= 1'b0;
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         ena_r <= ena_nxt;
         vec_r <= vec_nxt;
         nmi_r <= nmi_nxt;
         pf_prev_r <= pf_prev_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bus_rdata = rdata_r;
   assign bus_rvalid = rvalid_r;
   assign irq_req = irq_r;
   assign nmi_req = nmi_r[NMI_PIN_BIT]; // R22

endmodule
`default_nettype wire

// >>> verif/icu_checker_assertions.sv
// port checker for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module icu_checker
   import icu_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic rst_b, // sync reset, active low
   input wire logic [ADDR_W-1:0] bus_addr, // register address
   input wire logic bus_rd, // read strobe
   input wire logic [DATA_W-1:0] bus_rdata, // read data
   input wire logic bus_rvalid, // read valid
   input wire logic power_fail_input, // nmi pin
   input wire logic nmi_req // nmi to core
);
   // ----------------------------------------
   // bus answers and register contents
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // read data stands one cycle only, so check in that cycle
   a_read_answer: assert property (bus_rd |=> bus_rvalid)
      else $error("read got no answer");
   a_idle_quiet: assert property (!bus_rd |=> !bus_rvalid && bus_rdata == 16'h0000)
      else $error("read data outside a read");
   a_vector_range: assert property (
      bus_rd && bus_addr == VECTOR_OFS |=> bus_rdata inside {[16'h0010:16'h002F]})
      else $error("vector out of range");
   a_vector_top_zero: assert property (
      bus_rd && bus_addr == VECTOR_OFS |=> bus_rdata[7:6] == 2'b00)
      else $error("vector top bits set");
   a_nmi_read_bit: assert property (
      bus_rd && bus_addr == NMI_STATUS_OFS |=> bus_rdata == {15'h0000, $past(nmi_req)})
      else $error("nmi status differs from request");
   // pin equal to its value one and three samples back: no new edge can race the clear
   a_nmi_read_clear: assert property (
      bus_rd && bus_addr == NMI_STATUS_OFS && power_fail_input == $past(power_fail_input)
      && power_fail_input == $past(power_fail_input, 3) |=> !nmi_req)
      else $error("nmi not cleared by read");
   a_clear_write_only: assert property (
      bus_rd && (bus_addr == CLR_LOW_OFS || bus_addr == CLR_HIGH_OFS) |=> bus_rdata == 16'h0000)
      else $error("clear register returned data");
   a_reserved_low: assert property (
      bus_rd && bus_addr == PEND_LOW_OFS |=> bus_rdata[15] == 1'b0 && bus_rdata[0] == 1'b0)
      else $error("reserved low channel pending");
   a_reserved_high: assert property (
      bus_rd && bus_addr == PEND_HIGH_OFS |=> bus_rdata[14:13] == 2'b00 && !bus_rdata[10])
      else $error("reserved high channel pending");
   c_vector_read: cover property (bus_rd && bus_addr == VECTOR_OFS);
   c_nmi_seen: cover property (nmi_req);
   c_pend_read: cover property (bus_rd && bus_addr == PEND_HIGH_OFS);
endmodule
bind maskable_nmi_interrupt_unit icu_checker u_chk (.clk, .rst_b, .bus_addr, .bus_rd,
   .bus_rdata, .bus_rvalid, .power_fail_input, .nmi_req);
`default_nettype wire

// >>> verif/core_model.sv
// core side: strobe bus accesses of the processor
`timescale 1ns/1ps
`default_nettype none
module core_model
(
   input wire logic clk, // core clock
   output logic [15:0] bus_addr = 16'h0000, // address
   output logic bus_rd = 1'b0, // read strobe
   output logic bus_wr = 1'b0, // write strobe
   output logic [15:0] bus_wdata = 16'h0000 // write data
);
   // ----------------------------------------
   // one-cycle strobe, address scrambled after
   // ----------------------------------------
   task automatic access(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      {bus_rd, bus_wr, bus_addr, bus_wdata} = {r, w, a, d};
      @(negedge clk);
      // stale values must not pass for held ones
      {bus_rd, bus_wr, bus_addr, bus_wdata} = {2'b00, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import icu_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] bus_addr, bus_wdata, bus_rdata, r, m, a, e_now;
   logic bus_rd, bus_wr, bus_rvalid, irq_req, nmi_req;
   logic [31:0] level_irq, pin_irq, pin_alt_fn, r32;
   logic tick, sh1, sh2, sh3, dsm, kbs, aux, tx, rx, ibf, pf, arm;
   int n_mismatch = 0;
   int n_tests = 0;
   int seed = 26;
   logic [15:0] expq[$];
   always #2.5 clk = ~clk;
   core_model core (.clk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata);
   maskable_nmi_interrupt_unit dut (.clk, .rst_b, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
      .bus_rdata, .bus_rvalid, .level_irq, .pin_irq, .pin_alt_fn,
      .system_tick_output(tick), .shift_irq_line_one(sh1), .shift_irq_line_two(sh2),
      .shift_irq_line_three(sh3), .disabled_shift_irq_enable(dsm), .keyboard_scan_irq(kbs),
      .auxiliary_monitor_irq(aux), .serial_tx_irq(tx), .serial_rx_irq(rx), .kbd_ibf(ibf),
      .power_fail_input(pf), .nmi_arm(arm), .irq_req, .nmi_req);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic rd(input logic [15:0] ad, input logic [15:0] ex);
      expq.push_back(ex);
      core.access(1'b1, 1'b0, ad, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      core.access(1'b0, 1'b1, ad, d);
   endtask
   // vector lags a source by two edges, three gives margin
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask
   // request lines have no strobe, so look at them at a settled falling edge
   task automatic chk(input logic got, input logic ex);
      n_tests++;
      if (got !== ex)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, ex);
      end
   endtask
   task automatic test_end(input string s);
      wait (expq.size() == 0);
      @(negedge clk);
      $display("test %s ended", s);
   endtask
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // oldest note against each answer; an empty queue yields x and fails
   always @(posedge clk)
   begin
      if (bus_rvalid === 1'b1)
      begin
         e_now = (expq.size() > 0) ? expq.pop_front() : 16'hXXXX;
         n_tests++;
         if (bus_rdata !== e_now)
         begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, bus_rdata, e_now);
         end
      end
   end
   initial
   begin
      #50000;
      n_mismatch++;
      test_done;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {level_irq, pin_irq, pin_alt_fn} = '0;
      {tick, sh1, dsm, kbs, aux, tx, rx, ibf, arm} = '0;
      {sh2, sh3, pf} = 3'b111;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      rd(VECTOR_OFS, 16'h0010);
      rd(NMI_STATUS_OFS, 16'h0000);
      rd(ENA_LOW_OFS, 16'h0000);
      chk(irq_req, 1'b0);
      chk(nmi_req, 1'b0);
      test_end("reset");
      // reserved enable bits kept clear: their storage is the design's choice
      for (int i = 0; i < 4; i++)
      begin
         r32 = $random(seed);
         a = i[0] ? ENA_HIGH_OFS : ENA_LOW_OFS;
         m = i[0] ? DEAD_CH_MASK[31:16] : DEAD_CH_MASK[15:0];
         r = r32[15:0] & ~m;
         wr(a, r);
         rd(a, r);
      end
      wr(ENA_LOW_OFS, 16'hFFFF);
      wr(ENA_HIGH_OFS, 16'hFFFF);
      test_end("enable");
      level_irq[2] = 1'b1;
      settle;
      rd(VECTOR_OFS, 16'h0012);
      chk(irq_req, 1'b1);
      ibf = 1'b1;
      settle;
      rd(VECTOR_OFS, 16'h0028);
      pin_irq[31] = 1'b1;
      settle;
      rd(VECTOR_OFS, 16'h0028);
      pin_alt_fn[31] = 1'b1;
      settle;
      rd(VECTOR_OFS, 16'h002F);
      {pin_irq[31], ibf, level_irq[2]} = 3'b000;
      settle;
      rd(VECTOR_OFS, 16'h0010);
      chk(irq_req, 1'b0);
      test_end("priority");
      // reserved channels driven from every side must stay silent
      level_irq = DEAD_CH_MASK;
      pin_irq = DEAD_CH_MASK;
      pin_alt_fn = '1;
      settle;
      rd(PEND_LOW_OFS, 16'h0000);
      rd(PEND_HIGH_OFS, 16'h0000);
      rd(VECTOR_OFS, 16'h0010);
      chk(irq_req, 1'b0);
      {level_irq, pin_irq} = '0;
      test_end("reserved");
      for (int i = 0; i < 4; i++)
      begin
         {kbs, aux, tx, rx} = 4'b1000 >> i;
         settle;
         rd(PEND_LOW_OFS, (i < 2) ? 16'h0800 : 16'h0000);
         rd(PEND_HIGH_OFS, (i < 2) ? 16'h0000 : 16'h0001);
      end
      {kbs, aux, tx, rx} = 4'b0000;
      test_end("merged");
      // one tick only: wake-up side leaves the tick channel off after
      tick = 1'b1;
      settle;
      tick = 1'b0;
      settle;
      rd(PEND_LOW_OFS, 16'h2000);
      wr(CLR_LOW_OFS, 16'h2000);
      rd(PEND_LOW_OFS, 16'h0000);
      {sh2, sh3} = 2'b00;
      settle;
      {sh2, sh3} = 2'b11;
      settle;
      rd(PEND_HIGH_OFS, 16'h000C);
      wr(CLR_HIGH_OFS, 16'h0004);
      rd(PEND_HIGH_OFS, 16'h0008);
      wr(CLR_HIGH_OFS, 16'h0008);
      sh1 = 1'b1;
      settle;
      rd(PEND_HIGH_OFS, 16'h0010);
      sh1 = 1'b0;
      settle;
      rd(PEND_HIGH_OFS, 16'h0000);
      {dsm, sh1} = 2'b11;
      settle;
      sh1 = 1'b0;
      settle;
      rd(PEND_HIGH_OFS, 16'h0010);
      wr(CLR_HIGH_OFS, 16'h0010);
      rd(PEND_HIGH_OFS, 16'h0000);
      rd(CLR_HIGH_OFS, 16'h0000);
      rd(16'hFE20, 16'h0000);
      test_end("edge");
      // a pin edge while disarmed must leave the status clear
      pf = 1'b0;
      settle;
      pf = 1'b1;
      settle;
      rd(NMI_STATUS_OFS, 16'h0000);
      arm = 1'b1;
      settle;
      pf = 1'b0;
      settle;
      settle;
      chk(nmi_req, 1'b1);
      rd(NMI_STATUS_OFS, 16'h0001);
      rd(NMI_STATUS_OFS, 16'h0000);
      chk(nmi_req, 1'b0);
      test_end("nmi");
      test_done;
   end
endmodule
`default_nettype wire
